// *** rtl/pfci_host.sv ***
// Host-side command sequencer for a byte-wide parallel flash.
// Assumes a single requester using a valid/ready handshake and flash pins on the far side.
`timescale 1ns/10ps
`include "pfci_cfg.svh"
module pfci_host #(
  parameter int unsigned PROG_CYC = `PFCI_PROG_CYC,
  parameter int unsigned SECTOR_CYC = `PFCI_SECTOR_CYC,
  parameter int unsigned CHIP_CYC = `PFCI_CHIP_CYC,
  parameter int unsigned HV_CYC = `PFCI_HV_CYC
) (
  input wire logic core_clk, // 100 MHz clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic cmd_valid, // Request present
  output logic cmd_ready, // Request taken when high with cmd_valid
  input wire pfci_pkg::pfci_req_t cmd, // Operation, address, data
  output logic rsp_valid, // Answer present, one-cycle pulse
  output pfci_pkg::pfci_rsp_t rsp, // Read data and error flag
  output logic [18:0] flash_addr, // Address pins
  output logic [7:0] flash_dq_out, // Data pins, driven value
  output logic flash_dq_oe, // Data pins driven by the host
  input wire logic [7:0] flash_dq_in, // Data pins, sampled value
  output logic flash_ce_n, // Chip enable, active low
  output logic flash_oe_n, // Output enable, active low
  output logic flash_we_n, // Write enable, active low
  output logic hv_ce, // High voltage on chip enable
  output logic hv_oe, // High voltage on output enable
  output logic hv_a9 // High voltage on address pin 9
);

  typedef enum {M_IDLE, M_PRE, M_PRE_W, M_SEQ, M_SEQ_W, M_POLL, M_POLL_W, M_RESP} pfci_mstate_t;

  pfci_mstate_t state_reg;
  pfci_pkg::pfci_req_t req_reg;
  logic [2:0] step_reg;
  logic [31:0] wait_reg;
  logic err_reg;
  logic have_prev_reg;
  logic [7:0] prev_reg;
  logic [7:0] rdata_reg;
  logic bus_start;
  logic bus_done;
  logic [7:0] bus_rdata;
  pfci_pkg::pfci_kind_t bus_kind;
  pfci_pkg::pfci_word_t bus_word;
  pfci_pkg::pfci_word_t seq_word;
  logic [31:0] limit;

  // ****************************************
  // Command sequence tables
  // ****************************************
  function automatic pfci_pkg::pfci_word_t word_of(input pfci_pkg::pfci_req_t r,
                                                   input logic [2:0] idx);
    pfci_pkg::pfci_word_t w;
    w.addr = `PFCI_ADDR_UNLOCK1;
    w.data = `PFCI_CMD_READ_MODE;
    if (r.op == pfci_pkg::OP_READ_MODE) begin
      w.data = `PFCI_CMD_READ_MODE;
    end else if (r.op == pfci_pkg::OP_PROGRAM && idx == 3'h3) begin
      w.addr = r.addr;
      w.data = r.data;
    end else begin
      case (idx)
        3'h0, 3'h3: begin
          w.data = `PFCI_CMD_UNLOCK1;
        end
        3'h1, 3'h4: begin
          w.addr = `PFCI_ADDR_UNLOCK2;
          w.data = `PFCI_CMD_UNLOCK2;
        end
        3'h2: begin
          case (r.op)
            pfci_pkg::OP_PROGRAM: w.data = `PFCI_CMD_PROGRAM;
            pfci_pkg::OP_ID_ENTER: w.data = `PFCI_CMD_ID_ENTER;
            default: w.data = `PFCI_CMD_ERASE_SETUP;
          endcase
        end
        default: begin
          if (r.op == pfci_pkg::OP_CHIP_ERASE) begin
            w.data = `PFCI_CMD_CHIP_ERASE;
          end else begin
            w.addr = r.addr;
            w.data = `PFCI_CMD_SECTOR_ERASE;
          end
        end
      endcase
    end
    return w;
  endfunction

  function automatic logic [2:0] last_of(input pfci_pkg::pfci_op_t op);
    case (op)
      pfci_pkg::OP_PROGRAM: last_of = 3'h3;
      pfci_pkg::OP_SECTOR_ERASE, pfci_pkg::OP_CHIP_ERASE: last_of = 3'h5;
      pfci_pkg::OP_ID_ENTER: last_of = 3'h2;
      default: last_of = 3'h0;
    endcase
  endfunction

  // ****************************************
  // Bus cycle selection
  // ****************************************
  always_comb begin
    seq_word = word_of(req_reg, step_reg);
    bus_start = (state_reg == M_PRE) || (state_reg == M_SEQ) || (state_reg == M_POLL);
    bus_word.addr = req_reg.addr;
    bus_word.data = req_reg.data;
    bus_kind = pfci_pkg::BK_READ;
    if (state_reg == M_SEQ) begin
      case (req_reg.op)
        pfci_pkg::OP_READ: bus_kind = pfci_pkg::BK_READ;
        pfci_pkg::OP_BOOT_LOCK: bus_kind = pfci_pkg::BK_LOCK;
        pfci_pkg::OP_BOOT_UNLOCK: bus_kind = pfci_pkg::BK_UNLOCK;
        default: begin
          bus_kind = pfci_pkg::BK_WRITE;
          bus_word = seq_word;
        end
      endcase
    end
    case (req_reg.op)
      pfci_pkg::OP_PROGRAM: limit = PROG_CYC;
      pfci_pkg::OP_SECTOR_ERASE: limit = SECTOR_CYC;
      default: limit = CHIP_CYC;
    endcase
  end

  assign cmd_ready = (state_reg == M_IDLE);

  // ****************************************
  // Operation sequencer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= M_IDLE;
      req_reg <= '0;
      step_reg <= 3'h0;
      err_reg <= 1'b0;
      have_prev_reg <= 1'b0;
      prev_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      case (state_reg)
        M_IDLE: begin
          if (cmd_valid) begin
            req_reg <= cmd;
            step_reg <= 3'h0;
            err_reg <= 1'b0;
            rdata_reg <= 8'h00;
            // Programming can only clear bits, so the old byte is read first.
            state_reg <= (cmd.op == pfci_pkg::OP_PROGRAM) ? M_PRE : M_SEQ;
          end
        end
        M_PRE: state_reg <= M_PRE_W;
        M_PRE_W: begin
          if (bus_done) begin
            rdata_reg <= bus_rdata;
            if ((bus_rdata & req_reg.data) != req_reg.data) begin
              err_reg <= 1'b1;
              state_reg <= M_RESP;
            end else begin
              state_reg <= M_SEQ;
            end
          end
        end
        M_SEQ: state_reg <= M_SEQ_W;
        M_SEQ_W: begin
          if (bus_done) begin
            if (step_reg != last_of(req_reg.op)) begin
              step_reg <= step_reg + 3'h1;
              state_reg <= M_SEQ;
            end else if (req_reg.op == pfci_pkg::OP_PROGRAM ||
                         req_reg.op == pfci_pkg::OP_SECTOR_ERASE ||
                         req_reg.op == pfci_pkg::OP_CHIP_ERASE) begin
              have_prev_reg <= 1'b0;
              state_reg <= M_POLL;
            end else begin
              // Only a plain read takes data from this cycle; ID entry, read mode and boot commands answer zero, a timed-out operation its last poll byte.
              if (req_reg.op == pfci_pkg::OP_READ) begin
                rdata_reg <= bus_rdata;
              end
              state_reg <= M_RESP;
            end
          end
        end
        M_POLL: state_reg <= M_POLL_W;
        M_POLL_W: begin
          if (bus_done && wait_reg >= limit) begin
            // A stuck operation is abandoned by writing the read mode command.
            err_reg <= 1'b1;
            req_reg.op <= pfci_pkg::OP_READ_MODE;
            step_reg <= 3'h0;
            state_reg <= M_SEQ;
          end else if (bus_done) begin
            rdata_reg <= bus_rdata;
            prev_reg <= bus_rdata;
            have_prev_reg <= 1'b1;
            if (req_reg.op == pfci_pkg::OP_PROGRAM) begin
              if (bus_rdata[`PFCI_POLL_BIT] == req_reg.data[`PFCI_POLL_BIT]) begin
                err_reg <= (bus_rdata != req_reg.data);
                state_reg <= M_RESP;
              end else begin
                state_reg <= M_POLL;
              end
            end else if (have_prev_reg &&
                         bus_rdata[`PFCI_TOGGLE_BIT] == prev_reg[`PFCI_TOGGLE_BIT]) begin
              err_reg <= (req_reg.op == pfci_pkg::OP_SECTOR_ERASE) && (bus_rdata != 8'hFF);
              state_reg <= M_RESP;
            end else begin
              state_reg <= M_POLL;
            end
          end
        end
        M_RESP: state_reg <= M_IDLE;
        default: state_reg <= M_IDLE;
      endcase
    end
  end

  // ****************************************
  // Completion timeout counter
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst || state_reg == M_SEQ_W) begin
      wait_reg <= 32'h00000000;
    end else if ((state_reg == M_POLL || state_reg == M_POLL_W) && wait_reg != 32'hFFFFFFFF) begin
      wait_reg <= wait_reg + 32'h00000001;
    end
  end

  // ****************************************
  // Answer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= (state_reg == M_RESP);
      if (state_reg == M_RESP) begin
        rsp.data <= rdata_reg;
        rsp.err <= err_reg;
      end
    end
  end

  pfci_bus_cycle #(
    .HV_CYC(HV_CYC)
  ) u_bus (
    .core_clk(core_clk),
    .srst(srst),
    .start(bus_start),
    .kind(bus_kind),
    .word(bus_word),
    .done(bus_done),
    .rdata(bus_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .hv_ce(hv_ce),
    .hv_oe(hv_oe),
    .hv_a9(hv_a9)
  );

endmodule

// *** rtl/pfci_cfg.svh ***
// Constants for the parallel flash command host: timings, command codes and unlock addresses.
// Assumes a 100 MHz core_clk; cycle counts are derived from the printed times.
`ifndef PFCI_CFG_SVH
`define PFCI_CFG_SVH

`define PFCI_CLK_MHZ 100
`define PFCI_T_WP_NS 45
`define PFCI_T_WPH_NS 30
`define PFCI_T_ACC_NS 90
`define PFCI_T_DF_NS 40
`define PFCI_T_PROG_US 60
`define PFCI_T_SECTOR_MS 10
`define PFCI_T_CHIP_S 3
`define PFCI_T_HV_US 100
`define PFCI_WP_CYC ((`PFCI_T_WP_NS * `PFCI_CLK_MHZ + 999) / 1000)
`define PFCI_WPH_CYC ((`PFCI_T_WPH_NS * `PFCI_CLK_MHZ + 999) / 1000)
`define PFCI_ACC_CYC ((`PFCI_T_ACC_NS * `PFCI_CLK_MHZ + 999) / 1000)
`define PFCI_DF_CYC ((`PFCI_T_DF_NS * `PFCI_CLK_MHZ + 999) / 1000)
`define PFCI_SYNC_CYC 2
`define PFCI_PROG_CYC (`PFCI_T_PROG_US * `PFCI_CLK_MHZ)
`define PFCI_SECTOR_CYC (`PFCI_T_SECTOR_MS * 1000 * `PFCI_CLK_MHZ)
`define PFCI_CHIP_CYC (`PFCI_T_CHIP_S * 1000000 * `PFCI_CLK_MHZ)
`define PFCI_HV_CYC (`PFCI_T_HV_US * `PFCI_CLK_MHZ)

`define PFCI_ADDR_UNLOCK1 19'h05555
`define PFCI_ADDR_UNLOCK2 19'h02AAA
`define PFCI_CMD_UNLOCK1 8'hAA
`define PFCI_CMD_UNLOCK2 8'h55
`define PFCI_CMD_PROGRAM 8'hA0
`define PFCI_CMD_ERASE_SETUP 8'h80
`define PFCI_CMD_SECTOR_ERASE 8'h30
`define PFCI_CMD_CHIP_ERASE 8'h10
`define PFCI_CMD_ID_ENTER 8'h90
`define PFCI_CMD_READ_MODE 8'hFF
`define PFCI_POLL_BIT 7
`define PFCI_TOGGLE_BIT 6

`endif

// *** rtl/pfci_pkg.sv ***
// Types shared by the flash command host and its bus cycle engine.
// Assumes a 19-bit byte address and an 8-bit data bus.
package pfci_pkg;

  typedef enum logic [2:0] {
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_CHIP_ERASE,
    OP_ID_ENTER,
    OP_READ_MODE,
    OP_BOOT_LOCK,
    OP_BOOT_UNLOCK
  } pfci_op_t;

  typedef enum logic [1:0] {
    BK_READ,
    BK_WRITE,
    BK_LOCK,
    BK_UNLOCK
  } pfci_kind_t;

  typedef struct packed {
    pfci_op_t op;
    logic [18:0] addr;
    logic [7:0] data;
  } pfci_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic err;
  } pfci_rsp_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] data;
  } pfci_word_t;

endpackage

// *** rtl/pfci_bus_cycle.sv ***
// One flash bus cycle: a read, a write, or a high-voltage boot block lock or unlock.
// Assumes level shifters turn hv_* requests into the high voltage on the named pins.
`timescale 1ns/10ps
`include "pfci_cfg.svh"
module pfci_bus_cycle #(
  parameter int unsigned HV_CYC = `PFCI_HV_CYC
) (
  input wire logic core_clk, // 100 MHz clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic start, // Begin a cycle, one-cycle pulse
  input wire pfci_pkg::pfci_kind_t kind, // Cycle kind
  input wire pfci_pkg::pfci_word_t word, // Address and write data
  output logic done, // Cycle finished, one-cycle pulse
  output logic [7:0] rdata, // Data captured by a read
  output logic [18:0] flash_addr, // Address pins
  output logic [7:0] flash_dq_out, // Data pins, driven value
  output logic flash_dq_oe, // Data pins driven by the host
  input wire logic [7:0] flash_dq_in, // Data pins, sampled value
  output logic flash_ce_n, // Chip enable, active low
  output logic flash_oe_n, // Output enable, active low
  output logic flash_we_n, // Write enable, active low
  output logic hv_ce, // High voltage on chip enable
  output logic hv_oe, // High voltage on output enable
  output logic hv_a9 // High voltage on address pin 9
);

  typedef enum {B_IDLE, B_ACTIVE, B_RECOVER} pfci_bstate_t;

  pfci_bstate_t state_reg;
  logic [23:0] cnt_reg;
  logic [7:0] dq_meta_reg;
  logic [7:0] dq_sync_reg;
  logic is_read_reg;

  // ****************************************
  // Data pin synchroniser
  // ****************************************
  always_ff @(posedge core_clk) begin
    dq_meta_reg <= flash_dq_in;
    dq_sync_reg <= dq_meta_reg;
  end

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= B_IDLE;
      cnt_reg <= 24'h000000;
      is_read_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      flash_addr <= 19'h00000;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      hv_ce <= 1'b0;
      hv_oe <= 1'b0;
      hv_a9 <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        B_IDLE: begin
          if (start) begin
            flash_addr <= word.addr;
            flash_dq_out <= word.data;
            is_read_reg <= (kind == pfci_pkg::BK_READ);
            state_reg <= B_ACTIVE;
            case (kind)
              pfci_pkg::BK_READ: begin
                // Write enable is already high while chip and output enable drop.
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
                cnt_reg <= 24'(`PFCI_ACC_CYC + `PFCI_SYNC_CYC - 1);
              end
              pfci_pkg::BK_WRITE: begin
                // Both strobes fall and rise together, so either edge may latch.
                flash_dq_oe <= 1'b1;
                flash_ce_n <= 1'b0;
                flash_we_n <= 1'b0;
                cnt_reg <= 24'(`PFCI_WP_CYC - 1);
              end
              pfci_pkg::BK_LOCK: begin
                flash_ce_n <= 1'b0;
                flash_we_n <= 1'b0;
                hv_oe <= 1'b1;
                hv_a9 <= 1'b1;
                cnt_reg <= 24'(HV_CYC - 1);
              end
              default: begin
                flash_we_n <= 1'b0;
                hv_ce <= 1'b1;
                hv_oe <= 1'b1;
                hv_a9 <= 1'b1;
                cnt_reg <= 24'(HV_CYC - 1);
              end
            endcase
          end
        end
        B_ACTIVE: begin
          if (cnt_reg != 24'h000000) begin
            cnt_reg <= cnt_reg - 24'h000001;
          end else begin
            if (is_read_reg) begin
              rdata <= dq_sync_reg;
              cnt_reg <= 24'(`PFCI_DF_CYC - 1);
            end else begin
              cnt_reg <= 24'(`PFCI_WPH_CYC - 1);
            end
            // Data stays driven through recovery so it is valid at the rising edge.
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            hv_ce <= 1'b0;
            hv_oe <= 1'b0;
            hv_a9 <= 1'b0;
            state_reg <= B_RECOVER;
          end
        end
        B_RECOVER: begin
          // After a read the flash needs time to release the data pins.
          if (cnt_reg != 24'h000000) begin
            cnt_reg <= cnt_reg - 24'h000001;
          end else begin
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
            state_reg <= B_IDLE;
          end
        end
        default: begin
          state_reg <= B_IDLE;
        end
      endcase
    end
  end

endmodule

// *** bench/pfci_host_props.sv ***
// Concurrent checks on the pins and handshake of the flash command host.
// Assumes it is bound to pfci_host and sees only that module's ports.
`timescale 1ns/10ps
module pfci_host_props (
  input wire logic core_clk, // Clock
  input wire logic srst, // Reset
  input wire logic cmd_valid, // Request present
  input wire logic cmd_ready, // Request taken
  input wire pfci_pkg::pfci_req_t cmd, // Request
  input wire logic rsp_valid, // Answer pulse
  input wire pfci_pkg::pfci_rsp_t rsp, // Answer
  input wire logic [18:0] flash_addr, // Address pins
  input wire logic [7:0] flash_dq_out, // Driven data
  input wire logic flash_dq_oe, // Host drives data
  input wire logic [7:0] flash_dq_in, // Sampled data
  input wire logic flash_ce_n, // Chip enable
  input wire logic flash_oe_n, // Output enable
  input wire logic flash_we_n, // Write enable
  input wire logic hv_ce, // High voltage chip enable
  input wire logic hv_oe, // High voltage output enable
  input wire logic hv_a9 // High voltage address pin
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ****************************************
  // Pin relations.
  // ****************************************
  a_idle_after_reset: assert property ($fell(srst) |-> flash_ce_n && flash_oe_n && flash_we_n
    && !flash_dq_oe) else $error("strobes not idle after reset");
  a_read_we_high: assert property (!flash_ce_n && !flash_oe_n |-> flash_we_n)
    else $error("write enable low during read");
  a_write_oe_high: assert property (!flash_we_n |-> flash_oe_n)
    else $error("output enable low during write");
  a_no_contention: assert property (flash_dq_oe |-> flash_oe_n)
    else $error("host drives data while flash outputs");
  a_standby_no_read: assert property (flash_ce_n && !hv_ce |-> flash_oe_n)
    else $error("output enable low without chip enable");
  a_write_pulse: assert property ($fell(flash_we_n) && !hv_a9 |->
    (!flash_we_n && !flash_ce_n)[*5] ##1 (flash_we_n && flash_ce_n))
    else $error("write strobe width wrong");
  a_write_latch_stable: assert property (!flash_we_n |=> $stable(flash_addr)
    && $stable(flash_dq_out)) else $error("address or data moved in write strobe");
  a_read_held: assert property ($fell(flash_oe_n) |=>
    (!flash_oe_n && !flash_ce_n && $stable(flash_addr))[*8]) else $error("read cut short");
  a_lock_pins: assert property (hv_a9 && !hv_ce |-> hv_oe && !flash_ce_n && !flash_we_n)
    else $error("lock pin levels wrong");
  a_unlock_pins: assert property (hv_ce |-> hv_oe && hv_a9 && !flash_we_n)
    else $error("unlock pin levels wrong");
  a_read_answer: assert property (cmd_valid && cmd_ready && cmd.op == pfci_pkg::OP_READ
    |-> ##[18:20] rsp_valid) else $error("read answer late");
  c_read: cover property (!flash_ce_n && !flash_oe_n);
  c_lock: cover property (hv_a9 && !hv_ce);
  c_err: cover property (rsp_valid && rsp.err);
endmodule
bind pfci_host pfci_host_props u_pfci_host_props (.core_clk(core_clk), .srst(srst),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .hv_ce(hv_ce), .hv_oe(hv_oe), .hv_a9(hv_a9));

// *** bench/pfci_flash_model.sv ***
// Behavioural model of the byte-wide flash on the far side of the command host.
// Assumes registered host pins, sampled on core_clk, and a top boot block.
`timescale 1ns/10ps
module pfci_flash_model #(
  parameter int BUSY_CYC = 60,
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEVICE_CODE = 8'hC3 // Arbitrary value.
) (
  input wire logic core_clk, // Sampling clock
  input wire logic [18:0] flash_addr, // Address pins
  input wire logic [7:0] flash_dq_out, // Data from host
  input wire logic flash_ce_n, // Chip enable
  input wire logic flash_oe_n, // Output enable
  input wire logic flash_we_n, // Write enable
  input wire logic hv_ce, // High voltage chip enable
  input wire logic hv_oe, // High voltage output enable
  input wire logic hv_a9, // High voltage address pin
  output logic [7:0] model_dq // Data pins from flash
);
  logic [7:0] mem [int];
  logic [7:0] pd = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] v;
  logic [18:0] a_lat = '0;
  logic wr_prev = 1'b0, rd_prev = 1'b0, tog = 1'b0, boot_lock = 1'b0, id_mode = 1'b0, prog = 1'b0;
  int step = 0;
  int busy = 0;
  wire wr_act = !flash_ce_n && !flash_we_n && flash_oe_n && !hv_oe && !hv_a9 && !hv_ce;
  wire rd_act = !flash_ce_n && !flash_oe_n && flash_we_n && !hv_a9;
  initial model_dq = 8'hFF;
  function automatic logic [7:0] peek(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction
  function automatic logic locked(input logic [18:0] a);
    return boot_lock && a[18:14] == 5'h1F;
  endfunction
  task automatic bus_write(input logic [18:0] a, input logic [7:0] d);
    if (busy > 0) begin
      step = 0;
    end else if (step == 3) begin
      if (!locked(a)) begin
        mem[int'(a)] = peek(a) & d;
        pd = d;
        prog = 1'b1;
        busy = BUSY_CYC;
      end
      step = 0;
    end else if (step == 6 && (d == 8'h30 || (d == 8'h10 && a == 19'h05555))) begin
      foreach (mem[k]) begin
        if ((d == 8'h10 || k[18:10] == a[18:10]) && !locked(k[18:0])) mem[k] = 8'hFF;
      end
      prog = 1'b0;
      busy = BUSY_CYC;
      step = 0;
    end else if (d == 8'hAA && a == 19'h05555 && (step == 0 || step == 4)) begin
      step++;
    end else if (d == 8'h55 && a == 19'h02AAA && (step == 1 || step == 5)) begin
      step++;
    end else if (step == 2 && a == 19'h05555 && d inside {8'hA0, 8'h80, 8'h90}) begin
      step = (d == 8'hA0) ? 3 : (d == 8'h80) ? 4 : 0;
      id_mode = (d == 8'h90);
    end else begin
      step = 0;
      id_mode = 1'b0;
    end
  endtask
  always @(posedge core_clk) begin
    if (busy > 0) busy--;
    if (!flash_ce_n && !flash_we_n && hv_oe && hv_a9 && !hv_ce) boot_lock = 1'b1;
    if (hv_ce && hv_oe && hv_a9 && !flash_we_n) boot_lock = 1'b0;
    if (wr_act && !wr_prev) a_lat = flash_addr;
    if (!wr_act && wr_prev) bus_write(a_lat, flash_dq_out);
    if (!rd_act && rd_prev && busy > 0) tog = ~tog;
    if (busy > 0) v = {prog ? ~pd[7] : 1'b0, tog, 6'h00};
    else if (id_mode) v = flash_addr[0] ? DEVICE_CODE : MAKER_CODE;
    else v = peek(flash_addr);
    if (rd_act) last = v;
    model_dq <= rd_act ? v : ~last;
    wr_prev = wr_act;
    rd_prev = rd_act;
  end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the flash command host against a behavioural flash.
// Assumes the host package and the flash model are compiled first.
`timescale 1ns/10ps
module tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  pfci_pkg::pfci_req_t cmd = '0;
  pfci_pkg::pfci_rsp_t rsp;
  logic cmd_ready, rsp_valid, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, hv_ce, hv_oe, hv_a9;
  logic [18:0] flash_addr;
  logic [7:0] flash_dq_out, model_dq, flash_dq_in;
  int fail_count = 0;
  int cmp_count = 0;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
  localparam logic [7:0] DEVICE = 8'hC3; // Arbitrary value.
  always #5 core_clk = ~core_clk;
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : model_dq;
  pfci_host #(.PROG_CYC(200), .SECTOR_CYC(500), .CHIP_CYC(500), .HV_CYC(8)) u_pfci_host (
    .core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .hv_ce(hv_ce), .hv_oe(hv_oe), .hv_a9(hv_a9));
  pfci_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_pfci_flash_model (
    .core_clk(core_clk), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .hv_ce(hv_ce), .hv_oe(hv_oe), .hv_a9(hv_a9), .model_dq(model_dq));
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Entered and left one step after a rising edge.
  task automatic run_op(input pfci_pkg::pfci_op_t op, input logic [18:0] a, input logic [7:0] d,
                        input logic exp_err);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd.op = op;
    cmd.addr = a;
    cmd.data = d;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_flag("rsp_valid", 1'b1, rsp_valid);
    chk_flag("rsp.err", exp_err, rsp.err);
  endtask
  task automatic read_exp(input logic [18:0] a, input logic [7:0] exp);
    run_op(pfci_pkg::OP_READ, a, 8'h00, 1'b0);
    chk_byte("read data", exp, rsp.data);
  endtask
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic t_program();
    read_exp(19'h00123, 8'hFF);
    run_op(pfci_pkg::OP_PROGRAM, 19'h00400, 8'h5A, 1'b0);
    run_op(pfci_pkg::OP_PROGRAM, 19'h00800, 8'h3C, 1'b0);
    read_exp(19'h00400, 8'h5A);
    run_op(pfci_pkg::OP_PROGRAM, 19'h00400, 8'hA5, 1'b1);
    chk_byte("old byte", 8'h5A, rsp.data);
  endtask
  task automatic t_sector();
    run_op(pfci_pkg::OP_SECTOR_ERASE, 19'h007FF, 8'h00, 1'b0);
    read_exp(19'h00400, 8'hFF);
    read_exp(19'h00800, 8'h3C);
  endtask
  task automatic t_ident();
    run_op(pfci_pkg::OP_ID_ENTER, 19'h00000, 8'h00, 1'b0);
    chk_byte("id answer", 8'h00, rsp.data);
    read_exp(19'h00000, MAKER);
    read_exp(19'h00001, DEVICE);
    run_op(pfci_pkg::OP_READ_MODE, 19'h00000, 8'h00, 1'b0);
    read_exp(19'h00800, 8'h3C);
  endtask
  task automatic t_boot();
    run_op(pfci_pkg::OP_BOOT_LOCK, 19'h00000, 8'h00, 1'b0);
    run_op(pfci_pkg::OP_PROGRAM, 19'h7C010, 8'h00, 1'b1);
    read_exp(19'h7C010, 8'hFF);
    run_op(pfci_pkg::OP_PROGRAM, 19'h7BFFF, 8'h00, 1'b0);
    run_op(pfci_pkg::OP_BOOT_UNLOCK, 19'h00000, 8'h00, 1'b0);
    run_op(pfci_pkg::OP_PROGRAM, 19'h7FFFF, 8'h11, 1'b0);
    read_exp(19'h7FFFF, 8'h11);
  endtask
  task automatic t_chip();
    run_op(pfci_pkg::OP_CHIP_ERASE, 19'h00000, 8'h00, 1'b0);
    read_exp(19'h00800, 8'hFF);
    read_exp(19'h7FFFF, 8'hFF);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    srst = 1'b0;
    t_program();
    t_sector();
    t_ident();
    t_boot();
    t_chip();
    conclude();
  end
  initial begin
    #500000;
    fail_count++;
    $display("[ERR] watchdog expected finish seen hang");
    conclude();
  end
endmodule
